// [bpss_consts.svh]
// Offsets, reset values, codes and timing figures of the power state sequencer
`ifndef BPSS_CONSTS_SVH
`define BPSS_CONSTS_SVH

`define BPSS_OFF_CTRL 8'h00
`define BPSS_OFF_STATUS 8'h04
`define BPSS_OFF_TRIM 8'h08

`define BPSS_CTRL_ADJ_ALLOW_BIT 0
`define BPSS_CTRL_RST 1'b1
`define BPSS_STATUS_STATE_LSB 8

`define BPSS_RESP_OKAY 2'h0
`define BPSS_RESP_SLVERR 2'h2

`define BPSS_RATE_OFF 2'h0
`define BPSS_RATE_4MHZ 2'h1
`define BPSS_RATE_8MHZ 2'h2
`define BPSS_RATE_16MHZ 2'h3

`define BPSS_TRIM_WORDS 8
`define BPSS_CORE_CLK_MHZ 25
`define BPSS_BUS_FILTER_US 2000
`define BPSS_BUS_FILTER_CYCLES (`BPSS_BUS_FILTER_US * `BPSS_CORE_CLK_MHZ)

`endif

// [bpss_host_model.sv]
// Host model that follows the reset, warning and clock lines
`timescale 1ns/1ps
`default_nettype none
module bpss_host_model (
	input wire logic core_clk, // Core clock
	input wire logic hostResetN, // Host reset from block
	input wire logic powerWarningN, // Power warning from block
	input wire logic [1:0] hostClockRate, // Host clock rate code
	output logic hostRunning, // Host out of reset with a clock
	output logic hostSaving // Host cutting load and saving data
);
	// Bus bit coding and the inverted data pins stay with the host
	always_ff @(posedge core_clk) begin
		hostRunning <= hostResetN && (hostClockRate != 2'h0);
		hostSaving <= hostResetN && !powerWarningN;
	end
endmodule
`default_nettype wire

// [bpss_pkg.sv]
// Types of the power state sequencer
package bpss_pkg;
	typedef enum logic [3:0] {
		ST_RESET = 4'b0001,
		ST_STARTUP = 4'b0010,
		ST_STANDBY = 4'b0100,
		ST_NORMAL = 4'b1000
	} bpss_state_e;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} bpss_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bpss_axi_rsp_s;

	// Supervisor comparator levels, high means above threshold or good
	typedef struct packed {
		logic thermalWarning;
		logic thermalShutdown;
		logic xtalGood;
		logic busAboveLow;
		logic filtStart;
		logic filtAboveHigh;
		logic filtAboveLow;
		logic filtAboveSave;
		logic filtAboveFixed;
		logic fixedGood;
		logic adjGood;
		logic auxGood;
		logic hostClockSelect;
	} bpss_mon_s;

	typedef struct packed {
		bpss_state_e st;
		logic [3:0] trimCnt;
		logic [7:0] trimSum;
		logic [15:0] busLowCnt;
		logic busLowLong;
		logic fixedBuckEn;
		logic adjBuckEn;
		logic auxEn;
		logic adjLock;
		logic [1:0] clkRate;
		logic hostResetN;
		logic powerWarningN;
		logic ctrlAdjAllow;
		logic [5:0] status;
		logic awGot;
		logic [7:0] awAddr;
		logic wGot;
		logic [31:0] wData;
		logic wStrb0;
		logic awRdy;
		logic wRdy;
		logic arRdy;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} bpss_state_s;
endpackage

// [bpss_sequencer.sv]
// Power state sequencer with supervisor inputs and AXI4-Lite register slave
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`include "bpss_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bpss_sequencer #(
	parameter int BUS_FILTER_CYCLES = `BPSS_BUS_FILTER_CYCLES
) (
	input wire logic core_clk, // 25 MHz core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire bpss_pkg::bpss_mon_s monIn, // Raw supervisor levels
	input wire bpss_pkg::bpss_axi_req_s axiReq, // AXI4-Lite master signals
	output bpss_pkg::bpss_axi_rsp_s axiRsp, // AXI4-Lite slave signals
	output logic hostResetN, // Host reset, low holds host in reset
	output logic powerWarningN, // Power warning, low signals trouble
	output logic [1:0] hostClockRate, // Host clock rate code to oscillator
	output logic fixedBuckEn, // Fixed buck enable
	output logic adjBuckEn, // Adjustable buck enable
	output logic auxEn // 20 V regulator enable
);
	localparam logic [15:0] BUS_LIM = 16'(BUS_FILTER_CYCLES - 1);
	localparam logic [3:0] TRIM_LAST = 4'(`BPSS_TRIM_WORDS);

	bpss_pkg::bpss_mon_s m;
	bpss_pkg::bpss_state_s stateQ;
	bpss_pkg::bpss_state_s stateD;
	logic [7:0] trimData;
	logic awTake;
	logic wTake;
	logic arTake;
	logic allGood;
	logic cutOff;

	// Comparator levels are asynchronous to the core clock
	bpss_sync #(
		.W($bits(bpss_pkg::bpss_mon_s))
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.din(monIn),
		.dout(m)
	);

	bpss_trim_rom u_trim (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.addr(stateQ.trimCnt[2:0]),
		.data(trimData)
	);

	always_comb begin
		stateD = stateQ;
		awTake = axiReq.awvalid && stateQ.awRdy;
		wTake = axiReq.wvalid && stateQ.wRdy;
		arTake = axiReq.arvalid && stateQ.arRdy;
		allGood = m.busAboveLow && !stateQ.busLowLong && m.filtAboveHigh && m.adjGood
			&& m.auxGood && m.xtalGood && !m.thermalWarning;
		cutOff = !m.adjGood || !m.auxGood;
		// Live flags, shutdown deliberately left out
		stateD.status = {m.thermalWarning, m.xtalGood, m.busAboveLow,
			m.filtAboveHigh, m.adjGood, m.auxGood};
		// Bus low filter
		if (m.busAboveLow) begin
			stateD.busLowCnt = 16'h0000;
			stateD.busLowLong = 1'b0;
		end else if (stateQ.busLowCnt == BUS_LIM) begin
			stateD.busLowLong = 1'b1;
		end else begin
			stateD.busLowCnt = stateQ.busLowCnt + 16'h0001;
		end
		case (stateQ.st)
			bpss_pkg::ST_RESET: begin
				stateD.fixedBuckEn = 1'b0;
				stateD.adjBuckEn = 1'b0;
				stateD.auxEn = 1'b0;
				stateD.clkRate = `BPSS_RATE_OFF;
				stateD.trimCnt = 4'h0;
				stateD.trimSum = 8'h00;
				// A supply fault lock lasts until the next pass through reset
				stateD.adjLock = 1'b0;
				if (!m.thermalShutdown && m.filtStart) begin
					stateD.st = bpss_pkg::ST_STARTUP;
					stateD.fixedBuckEn = 1'b1;
				end
			end
			bpss_pkg::ST_STARTUP: begin
				if (m.fixedGood) begin
					// Word k arrives one cycle after its address
					stateD.trimCnt = stateQ.trimCnt + 4'h1;
					if (stateQ.trimCnt != 4'h0) begin
						stateD.trimSum = stateQ.trimSum ^ trimData;
					end
					if (stateQ.trimCnt == TRIM_LAST) begin
						stateD.st = bpss_pkg::ST_STANDBY;
						stateD.trimCnt = 4'h0;
						stateD.clkRate = `BPSS_RATE_4MHZ;
					end
				end
			end
			bpss_pkg::ST_STANDBY: begin
				// Not restarted after leaving normal on their own fault
				if (m.filtAboveHigh && stateQ.ctrlAdjAllow && !stateQ.adjLock) begin
					stateD.adjBuckEn = 1'b1;
					stateD.auxEn = 1'b1;
				end
				if (allGood) begin
					stateD.st = bpss_pkg::ST_NORMAL;
					stateD.clkRate = m.hostClockSelect ? `BPSS_RATE_16MHZ : `BPSS_RATE_8MHZ;
				end
			end
			bpss_pkg::ST_NORMAL: begin
				stateD.clkRate = m.hostClockSelect ? `BPSS_RATE_16MHZ : `BPSS_RATE_8MHZ;
				// Shutdown is routed through stand-by first
				if (m.thermalWarning || m.thermalShutdown || stateQ.busLowLong
						|| !m.xtalGood || cutOff) begin
					stateD.st = bpss_pkg::ST_STANDBY;
					if (!m.xtalGood) begin
						stateD.clkRate = `BPSS_RATE_4MHZ;
					end
					if (cutOff) begin
						stateD.adjLock = 1'b1;
						stateD.adjBuckEn = 1'b0;
						stateD.auxEn = 1'b0;
					end
				end
			end
			default: begin
				stateD.st = bpss_pkg::ST_RESET;
			end
		endcase
		if (!m.filtAboveLow) begin
			stateD.adjBuckEn = 1'b0;
			stateD.auxEn = 1'b0;
		end
		if (!m.filtAboveFixed) begin
			stateD.fixedBuckEn = 1'b0;
		end
		if (!m.fixedGood && (stateQ.st == bpss_pkg::ST_STANDBY
				|| stateQ.st == bpss_pkg::ST_NORMAL)) begin
			stateD.st = bpss_pkg::ST_RESET;
			stateD.adjBuckEn = 1'b0;
			stateD.auxEn = 1'b0;
			stateD.clkRate = `BPSS_RATE_OFF;
		end
		if (m.thermalShutdown && stateQ.st != bpss_pkg::ST_NORMAL) begin
			stateD.st = bpss_pkg::ST_RESET;
			stateD.fixedBuckEn = 1'b0;
			stateD.adjBuckEn = 1'b0;
			stateD.auxEn = 1'b0;
			stateD.clkRate = `BPSS_RATE_OFF;
		end
		stateD.hostResetN = (stateD.st == bpss_pkg::ST_STANDBY)
			|| (stateD.st == bpss_pkg::ST_NORMAL);
		stateD.powerWarningN = (stateD.st == bpss_pkg::ST_NORMAL) && !m.thermalWarning
			&& m.filtAboveSave && !stateD.busLowLong;
		// Register slave: address and data taken in either order
		if (stateQ.bvalid && axiReq.bready) begin
			stateD.bvalid = 1'b0;
		end
		if (awTake) begin
			stateD.awGot = 1'b1;
			stateD.awAddr = axiReq.awaddr[7:0];
		end
		if (wTake) begin
			stateD.wGot = 1'b1;
			stateD.wData = axiReq.wdata;
			stateD.wStrb0 = axiReq.wstrb[0];
		end
		if (stateD.awGot && stateD.wGot && !stateQ.bvalid) begin
			stateD.awGot = 1'b0;
			stateD.wGot = 1'b0;
			stateD.bvalid = 1'b1;
			stateD.bresp = `BPSS_RESP_OKAY;
			if (stateD.awAddr == `BPSS_OFF_CTRL) begin
				if (stateD.wStrb0) begin
					stateD.ctrlAdjAllow = stateD.wData[`BPSS_CTRL_ADJ_ALLOW_BIT];
				end
			end else if (stateD.awAddr != `BPSS_OFF_STATUS && stateD.awAddr != `BPSS_OFF_TRIM) begin
				stateD.bresp = `BPSS_RESP_SLVERR;
			end
		end
		if (stateQ.rvalid && axiReq.rready) begin
			stateD.rvalid = 1'b0;
		end
		if (arTake) begin
			stateD.rvalid = 1'b1;
			stateD.rresp = `BPSS_RESP_OKAY;
			case (axiReq.araddr[7:0])
				`BPSS_OFF_CTRL: stateD.rdata = {31'h0, stateQ.ctrlAdjAllow};
				`BPSS_OFF_STATUS: stateD.rdata = {20'h0, stateQ.st, 2'h0, stateQ.status};
				`BPSS_OFF_TRIM: stateD.rdata = {24'h0, stateQ.trimSum};
				default: begin
					stateD.rdata = 32'h0;
					stateD.rresp = `BPSS_RESP_SLVERR;
				end
			endcase
		end
		stateD.awRdy = !stateD.awGot && !stateD.bvalid;
		stateD.wRdy = !stateD.wGot && !stateD.bvalid;
		stateD.arRdy = !stateD.rvalid;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= '0;
			stateQ.st <= bpss_pkg::ST_RESET;
			stateQ.ctrlAdjAllow <= `BPSS_CTRL_RST;
			stateQ.clkRate <= `BPSS_RATE_OFF;
		end else begin
			stateQ <= stateD;
		end
	end

	assign hostResetN = stateQ.hostResetN;
	assign powerWarningN = stateQ.powerWarningN;
	assign hostClockRate = stateQ.clkRate;
	assign fixedBuckEn = stateQ.fixedBuckEn;
	assign adjBuckEn = stateQ.adjBuckEn;
	assign auxEn = stateQ.auxEn;
	assign axiRsp.awready = stateQ.awRdy;
	assign axiRsp.wready = stateQ.wRdy;
	assign axiRsp.bvalid = stateQ.bvalid;
	assign axiRsp.bresp = stateQ.bresp;
	assign axiRsp.arready = stateQ.arRdy;
	assign axiRsp.rvalid = stateQ.rvalid;
	assign axiRsp.rdata = stateQ.rdata;
	assign axiRsp.rresp = stateQ.rresp;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence sTrimDone;
		stateQ.st == bpss_pkg::ST_STARTUP && m.fixedGood && stateQ.trimCnt == TRIM_LAST
			&& !m.thermalShutdown;
	endsequence

	sequence sEnterNormal;
		stateQ.st == bpss_pkg::ST_STANDBY ##1 stateQ.st == bpss_pkg::ST_NORMAL;
	endsequence

	chk_tsd_reset: assert property (
		m.thermalShutdown && stateQ.st != bpss_pkg::ST_NORMAL
		|=> stateQ.st == bpss_pkg::ST_RESET && !fixedBuckEn && !hostResetN)
		else $error("shutdown did not force reset");
	chk_tsd_normal: assert property (
		stateQ.st == bpss_pkg::ST_NORMAL && m.thermalShutdown && m.fixedGood
		|=> stateQ.st == bpss_pkg::ST_STANDBY ##1 stateQ.st == bpss_pkg::ST_RESET)
		else $error("overheat did not pass through stand-by");
	chk_warn_thermal: assert property (
		m.thermalWarning |=> !powerWarningN)
		else $error("warning output high during thermal warning");
	chk_warn_filt: assert property (
		!m.filtAboveSave |=> !powerWarningN)
		else $error("warning output high with filtered voltage low");
	chk_trim_done: assert property (
		sTrimDone |=> stateQ.st == bpss_pkg::ST_STANDBY && hostResetN
			&& hostClockRate == `BPSS_RATE_4MHZ)
		else $error("trim read did not lead to stand-by");
	chk_reset_start: assert property (
		stateQ.st == bpss_pkg::ST_RESET && m.filtStart && !m.thermalShutdown
			&& m.filtAboveFixed
		|=> stateQ.st == bpss_pkg::ST_STARTUP && fixedBuckEn)
		else $error("start-up not entered from reset");
	chk_normal_good: assert property (
		sEnterNormal |-> $past(m.adjGood) && $past(m.auxGood) && $past(m.busAboveLow)
			&& $past(m.filtAboveHigh) && !$past(m.thermalWarning))
		else $error("normal entered with a monitor not good");
	chk_normal_clk: assert property (
		stateQ.st == bpss_pkg::ST_NORMAL && $past(stateQ.st) == bpss_pkg::ST_NORMAL
		|-> hostClockRate == ($past(m.hostClockSelect) ? `BPSS_RATE_16MHZ : `BPSS_RATE_8MHZ))
		else $error("normal host clock rate wrong");
	chk_xtal_clk: assert property (
		stateQ.st == bpss_pkg::ST_NORMAL && !m.xtalGood && m.fixedGood
		|=> stateQ.st == bpss_pkg::ST_STANDBY && hostClockRate == `BPSS_RATE_4MHZ)
		else $error("crystal fault did not select 4 MHz");
	chk_keep_adj: assert property (
		stateQ.st == bpss_pkg::ST_NORMAL && adjBuckEn && !m.xtalGood && !cutOff
			&& m.filtAboveLow && m.fixedGood
		|=> adjBuckEn && auxEn)
		else $error("adjustable supply dropped without its own fault");
	chk_adj_lock: assert property (
		stateQ.adjLock |-> !adjBuckEn && !auxEn)
		else $error("faulted adjustable supply restarted");
	chk_adj_off: assert property (
		!m.filtAboveLow |=> !adjBuckEn && !auxEn)
		else $error("adjustable supply on below low threshold");
	chk_bus_long: assert property (
		stateQ.st == bpss_pkg::ST_NORMAL && stateQ.busLowLong
		|=> stateQ.st != bpss_pkg::ST_NORMAL && !powerWarningN)
		else $error("bus low did not leave normal");
endmodule
`default_nettype wire

// [bpss_sync.sv]
// Two-flop level synchroniser for a group of comparator inputs
`timescale 1ns/1ps
`default_nettype none
module bpss_sync #(
	parameter int W = 1
) (
	input wire logic core_clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [W-1:0] din, // Asynchronous levels
	output logic [W-1:0] dout // Synchronised levels
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [bpss_trim_rom.sv]
// Trim memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module bpss_trim_rom (
	input wire logic core_clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [2:0] addr, // Word address
	output logic [7:0] data // Word read one cycle after addr
);
	logic [7:0] word;

	always_comb begin
		case (addr)
			3'h0: word = 8'h5a;
			3'h1: word = 8'h3c;
			3'h2: word = 8'h81;
			3'h3: word = 8'h47;
			3'h4: word = 8'h92;
			3'h5: word = 8'h1e;
			3'h6: word = 8'h6d;
			3'h7: word = 8'hb0;
			default: word = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			data <= 8'h00;
		end else begin
			data <= word;
		end
	end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the power state sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	bpss_pkg::bpss_mon_s mon = '0;
	bpss_pkg::bpss_axi_req_s req = '0;
	bpss_pkg::bpss_axi_rsp_s rsp;
	logic hostResetN, powerWarningN, fixedBuckEn, adjBuckEn, auxEn;
	logic hostRunning, hostSaving;
	logic [1:0] hostClockRate;
	logic [31:0] outs, d, st;
	logic [1:0] r;
	int nMismatch = 0;
	int checked = 0;
	int cyc = 0;
	// Bits: 6 host reset, 5 warning, 4:3 rate, 2 fixed, 1 adjustable, 0 aux
	assign outs = {25'h0, hostResetN, powerWarningN, hostClockRate, fixedBuckEn, adjBuckEn, auxEn};
	bpss_sequencer #(.BUS_FILTER_CYCLES(20)) bpss_sequencer_i (.core_clk(core_clk),
		.rst_n(rst_n), .monIn(mon), .axiReq(req), .axiRsp(rsp), .hostResetN(hostResetN),
		.powerWarningN(powerWarningN), .hostClockRate(hostClockRate),
		.fixedBuckEn(fixedBuckEn), .adjBuckEn(adjBuckEn), .auxEn(auxEn));
	bpss_host_model bpss_host_model_i (.core_clk(core_clk), .hostResetN(hostResetN),
		.powerWarningN(powerWarningN), .hostClockRate(hostClockRate),
		.hostRunning(hostRunning), .hostSaving(hostSaving));
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			nMismatch++;
			conclude();
		end
	end
	task automatic conclude();
		$display("counts: %0d compared, %0d mismatched", checked, nMismatch);
		if (nMismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic axiWr(input logic [31:0] a, input logic [31:0] v);
		r = 2'h3;
		@(posedge core_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		while (r == 2'h3) begin
			@(posedge core_clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) r = rsp.bresp;
		end
		req.bready <= 1'b0;
	endtask
	task automatic axiRd(input logic [31:0] a);
		r = 2'h3;
		@(posedge core_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		while (r == 2'h3) begin
			@(posedge core_clk);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				r = rsp.rresp;
				d = rsp.rdata;
			end
		end
		req.rready <= 1'b0;
		st = {28'h0, d[11:8]};
	endtask
	task automatic tRegs();
		axiRd(32'h0);
		chk(d, 32'h1);
		axiRd(32'hc);
		chk(32'(r), 32'h2);
		axiWr(32'h4, 32'hffffffff);
		chk(32'(r), 32'h0);
		axiRd(32'h4);
		chk(st, 32'h1);
		$display("register test done");
	endtask
	task automatic tPowerUp();
		mon <= 13'h110;
		wt(5);
		chk(outs, 32'h4);
		axiRd(32'h4);
		chk(st, 32'h2);
		mon <= 13'h118;
		wt(16);
		chk(outs, 32'h4c);
		mon <= 13'h1f8;
		wt(5);
		chk(outs, 32'h4f);
		mon <= 13'h7fe;
		wt(6);
		chk(outs, 32'h77);
		axiRd(32'h4);
		chk(st, 32'h8);
		chk(d & 32'h3f, 32'h1f);
		mon <= 13'h7ff;
		wt(5);
		chk(outs, 32'h7f);
		chk(32'(hostRunning), 32'h1);
		$display("power-up test done");
	endtask
	task automatic tExits();
		mon.thermalWarning <= 1'b1;
		wt(5);
		chk(outs, 32'h5f);
		chk(32'(hostSaving), 32'h1);
		axiRd(32'h4);
		chk(st, 32'h4);
		chk(d & 32'h3f, 32'h3f);
		mon.thermalShutdown <= 1'b1;
		wt(5);
		chk(outs, 32'h0);
		wt(20);
		axiRd(32'h4);
		chk(st, 32'h1);
		mon.thermalShutdown <= 1'b0;
		wt(2);
		axiRd(32'h4);
		chk(st, 32'h2);
		wt(16);
		chk(outs, 32'h4f);
		mon.thermalWarning <= 1'b0;
		wt(6);
		chk(outs, 32'h7f);
		mon.xtalGood <= 1'b0;
		wt(5);
		chk(outs, 32'h4f);
		mon.xtalGood <= 1'b1;
		wt(6);
		chk(outs, 32'h7f);
		mon.busAboveLow <= 1'b0;
		wt(12);
		chk(outs, 32'h7f);
		mon.busAboveLow <= 1'b1;
		wt(3);
		mon.busAboveLow <= 1'b0;
		wt(30);
		chk(outs, 32'h5f);
		mon.busAboveLow <= 1'b1;
		wt(8);
		chk(outs, 32'h7f);
		mon.filtAboveSave <= 1'b0;
		wt(4);
		chk(outs, 32'h5f);
		mon.filtAboveSave <= 1'b1;
		wt(4);
		$display("exit test done");
	endtask
	task automatic tDown();
		mon.filtAboveHigh <= 1'b0;
		mon.filtAboveLow <= 1'b0;
		mon.filtAboveSave <= 1'b0;
		wt(5);
		chk(outs, 32'h5c);
		mon.filtAboveFixed <= 1'b0;
		wt(5);
		chk(outs, 32'h58);
		mon.fixedGood <= 1'b0;
		wt(5);
		chk(outs, 32'h0);
		$display("shut-down test done");
	endtask
	task automatic tCtrl();
		rst_n <= 1'b0;
		mon <= '0;
		wt(8);
		rst_n <= 1'b1;
		axiWr(32'h0, 32'h0);
		mon <= 13'h7f8;
		wt(30);
		chk(outs, 32'h4c);
		axiWr(32'h0, 32'h1);
		wt(5);
		chk(outs, 32'h4f);
		mon <= 13'h7fe;
		wt(6);
		chk(outs, 32'h77);
		mon.adjGood <= 1'b0;
		wt(5);
		chk(outs, 32'h54);
		$display("control test done");
	endtask
	initial begin
		wt(4);
		chk(outs, 32'h0);
		wt(4);
		rst_n <= 1'b1;
		tRegs();
		tPowerUp();
		tExits();
		tDown();
		tCtrl();
		conclude();
	end
endmodule
`default_nettype wire
